//--- logic/ubw_params.svh
// Purpose: Offsets, field positions and counts for the baud generator.
// Assumes: APB with 32-bit data, one word per register.
// Notes:   Register offsets, bit positions and prescale counts follow.
`ifndef UBW_PARAMS_SVH
`define UBW_PARAMS_SVH
`define UBW_OFS_CTRL    8'h00
`define UBW_OFS_DIV_LO  8'h04
`define UBW_OFS_DIV_HI  8'h08
`define UBW_OFS_STATUS  8'h0c
`define UBW_OFS_RXDATA  8'h10
`define UBW_B_S16       0
`define UBW_B_HR        1
`define UBW_B_SYNC      2
`define UBW_B_AUTOBAUD_ENABLE     3
`define UBW_B_WUE       4
`define UBW_B_OVF       5
`define UBW_B_RIF       0
`define UBW_B_IDLE      1
`define UBW_PRE_64      9'h03f
`define UBW_PRE_16      9'h00f
`define UBW_PRE_4       9'h003
`define UBW_PRE_512     9'h1ff
`define UBW_PRE_128     9'h07f
`define UBW_PRE_32      9'h01f
`define UBW_DIV_RST     16'h0000
`define UBW_CAL_START   16'h0001
`define UBW_LAST_RISE   3'h3
`endif

//--- logic/ubw_pkg.sv
// Purpose: Types shared by the baud generator.
// Assumes: Constants live in ubw_params.svh.
// Notes:   One-hot calibration and wake states.
package ubw_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_FALL  = 5'h02,
    ST_RISE1 = 5'h04,
    ST_COUNT = 5'h08,
    ST_WLOW  = 5'h10
  } ubw_state_t;
endpackage

//--- logic/ubw_baud_gen.sv
// Purpose: Baud divider with autobaud calibration and wake on break.
// Assumes: pclk 20 MHz; serial_rx_line is asynchronous.
// Notes:   Registers reached over APB with a registered pready and no wait state.
`timescale 1ns/1ps
`include "ubw_params.svh"
module ubw_baud_gen import ubw_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_rx_line,
  input  wire logic        rx_char_valid,
  output logic             baud_tick,
  output logic             receive_int_flag,
  output logic             receiver_idle_flag,
  output logic             rx_hold_idle
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Picks the prescaler terminal count for the mode and phase.
  function automatic logic [8:0] pre_max(input logic s16, input logic hr,
                                         input logic cal);
    logic [1:0] m;
    m = {s16, hr};
    case (m)
      2'b00:   pre_max = cal ? `UBW_PRE_512 : `UBW_PRE_64;
      2'b11:   pre_max = cal ? `UBW_PRE_32 : `UBW_PRE_4;
      default: pre_max = cal ? `UBW_PRE_128 : `UBW_PRE_16;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Receive line synchroniser
  // ---------------------------------------------------------------

  logic       rx_s1_q, rx_s2_q, rx_s3_q, rx_q;
  logic       rise_ev, fall_ev;

  // Three stages; a level counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
      rx_q    <= 1'b1;
    end else begin
      rx_s1_q <= serial_rx_line;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q) begin
        rx_q <= rx_s3_q;
      end
    end
  end

  // Edges of the filtered line.
  assign rise_ev = rx_s2_q & rx_s3_q & ~rx_q;
  assign fall_ev = ~rx_s2_q & ~rx_s3_q & rx_q;

  // ---------------------------------------------------------------
  // Registers, calibration and wake
  // ---------------------------------------------------------------

  ubw_state_t  st_q, st_d;
  logic        s16_q, s16_d, hr_q, hr_d, sync_q, sync_d;
  logic        autobaud_enable_q, autobaud_enable_d, wue_q, wue_d, ovf_q, ovf_d;
  logic        rif_q, rif_d, idle_q, idle_d, hold_d;
  logic [15:0] div_q, div_d;
  logic [2:0]  rise_q, rise_d;
  logic [8:0]  pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic        tick_d, pre_hit, cal, rif_set, wake_on;
  logic        wr, rd, div_wr;
  logic [31:0] rdat_d;
  logic        rdy_d, err_d, mapped;

  assign cal     = (st_q == ST_COUNT);
  assign pre_hit = (pre_q == pre_max(s16_q, hr_q & ~sync_q, cal));
  assign wake_on = wue_q & ~sync_q;
  assign wr      = psel & penable & pwrite & pready;
  assign rd      = psel & penable & ~pwrite & pready;
  assign div_wr  = wr & ((paddr == `UBW_OFS_DIV_LO) | (paddr == `UBW_OFS_DIV_HI));
  assign mapped  = (paddr <= `UBW_OFS_RXDATA) & (paddr[1:0] == 2'b00);

  // Bus decode, control bits, calibration and wake sequencing.
  always_comb begin
    st_d    = st_q;
    s16_d   = s16_q;
    hr_d    = hr_q;
    sync_d  = sync_q;
    autobaud_enable_d = autobaud_enable_q;
    wue_d   = wue_q;
    ovf_d   = ovf_q;
    div_d   = div_q;
    rise_d  = rise_q;
    rif_set = rx_char_valid;
    rdy_d   = psel & ~penable;
    err_d   = psel & ~penable & ~mapped;
    rdat_d  = 32'h0000_0000;
    case (paddr)
      `UBW_OFS_CTRL: begin
        rdat_d[`UBW_B_S16]   = s16_q;
        rdat_d[`UBW_B_HR]    = hr_q;
        rdat_d[`UBW_B_SYNC]  = sync_q;
        rdat_d[`UBW_B_AUTOBAUD_ENABLE] = autobaud_enable_q;
        rdat_d[`UBW_B_WUE]   = wue_q;
        rdat_d[`UBW_B_OVF]   = ovf_q;
      end
      `UBW_OFS_DIV_LO: rdat_d[7:0] = div_q[7:0];
      `UBW_OFS_DIV_HI: rdat_d[7:0] = div_q[15:8];
      `UBW_OFS_STATUS: begin
        rdat_d[`UBW_B_RIF]  = rif_q;
        rdat_d[`UBW_B_IDLE] = idle_q;
      end
      default: rdat_d = 32'h0000_0000;
    endcase
    // Software writes; the divisor belongs to hardware while counting.
    if (wr) begin
      case (paddr)
        `UBW_OFS_CTRL: begin
          s16_d   = pwdata[`UBW_B_S16];
          hr_d    = pwdata[`UBW_B_HR];
          sync_d  = pwdata[`UBW_B_SYNC];
          autobaud_enable_d = pwdata[`UBW_B_AUTOBAUD_ENABLE];
          wue_d   = pwdata[`UBW_B_WUE];
          ovf_d   = ovf_q & pwdata[`UBW_B_OVF];
        end
        `UBW_OFS_DIV_LO: if (st_q == ST_IDLE) div_d[7:0] = pwdata[7:0];
        `UBW_OFS_DIV_HI: if (st_q == ST_IDLE) div_d[15:8] = pwdata[7:0];
        default: ;
      endcase
    end
    // Sequencer; wake takes priority so calibration follows the break.
    case (st_q)
      ST_IDLE: begin
        if (wake_on && fall_ev) begin
          rif_set = 1'b1;
          st_d    = ST_WLOW;
        end else if (!wake_on && autobaud_enable_q) begin
          st_d = ST_FALL;
        end
      end
      ST_FALL: begin
        if (!autobaud_enable_d) st_d = ST_IDLE;
        else if (fall_ev) st_d = ST_RISE1;
      end
      ST_RISE1: begin
        if (!autobaud_enable_d) st_d = ST_IDLE;
        else if (rise_ev) begin
          div_d  = `UBW_CAL_START;
          rise_d = 3'h0;
          st_d   = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (rise_ev && rise_q == `UBW_LAST_RISE) begin
          autobaud_enable_d = 1'b0;
          rif_set = 1'b1;
          st_d    = ST_IDLE;
        end else if (!autobaud_enable_d) begin
          st_d = ST_IDLE;
        end else begin
          if (rise_ev) rise_d = rise_q + 3'h1;
          if (pre_hit) begin
            div_d = div_q + 16'h0001;
            if (div_q == 16'hffff) begin
              ovf_d   = 1'b1;
              rif_set = 1'b1;
            end
          end
        end
      end
      ST_WLOW: begin
        if (rise_ev) begin
          wue_d = 1'b0;
          st_d  = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // A new event wins over a same-cycle data read.
    rif_d  = rif_set | (rif_q & ~(rd & (paddr == `UBW_OFS_RXDATA)));
    idle_d = (st_d == ST_IDLE) | (st_d == ST_FALL);
    hold_d = (st_d != ST_IDLE) | autobaud_enable_d | (wue_d & ~sync_d);
  end

  // Registers the control, status and bus answer state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q               <= ST_IDLE;
      s16_q              <= 1'b0;
      hr_q               <= 1'b0;
      sync_q             <= 1'b0;
      autobaud_enable_q            <= 1'b0;
      wue_q              <= 1'b0;
      ovf_q              <= 1'b0;
      div_q              <= `UBW_DIV_RST;
      rise_q             <= 3'h0;
      rif_q              <= 1'b0;
      idle_q             <= 1'b1;
      prdata             <= 32'h0000_0000;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      receive_int_flag   <= 1'b0;
      receiver_idle_flag <= 1'b1;
      rx_hold_idle       <= 1'b0;
    end else begin
      st_q               <= st_d;
      s16_q              <= s16_d;
      hr_q               <= hr_d;
      sync_q             <= sync_d;
      autobaud_enable_q            <= autobaud_enable_d;
      wue_q              <= wue_d;
      ovf_q              <= ovf_d;
      div_q              <= div_d;
      rise_q             <= rise_d;
      rif_q              <= rif_d;
      idle_q             <= idle_d;
      prdata             <= rdat_d;
      pready             <= rdy_d;
      pslverr            <= err_d;
      receive_int_flag   <= rif_d;
      receiver_idle_flag <= idle_d;
      rx_hold_idle       <= hold_d;
    end
  end

  // ---------------------------------------------------------------
  // Baud divider, running only while the sequencer is in ST_IDLE
  // ---------------------------------------------------------------

  // Prescaler then period counter; a divisor write restarts both outside calibration, only the counter while counting.
  always_comb begin
    pre_d  = pre_hit ? 9'h000 : pre_q + 9'h001;
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (pre_hit && !cal) begin
      if (s16_q ? (cnt_q == div_q) : (cnt_q[7:0] == div_q[7:0])) begin
        cnt_d  = 16'h0000;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
    // A divisor write restarts the prescaler only at rest. While counting, the write is
    // refused, so the calibration prescale keeps its phase or the count would come short.
    if (div_wr || st_q != ST_IDLE) begin
      pre_d  = cal ? pre_d : 9'h000;
      cnt_d  = 16'h0000;
      tick_d = 1'b0;
    end
  end

  // Registers the divider state and its tick output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q     <= 9'h000;
      cnt_q     <= 16'h0000;
      baud_tick <= 1'b0;
    end else begin
      pre_q     <= pre_d;
      cnt_q     <= cnt_d;
      baud_tick <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_rise;
    cal && rise_ev && rise_q == 3'h3;
  endsequence

  AST_DIV_WR_CLR: assert property (div_wr |=> cnt_q == 16'h0000 && !baud_tick)
    else $error("Divider not cleared by divisor write.");
  AST_CAL_ONE: assert property ((st_q == ST_RISE1) && rise_ev && autobaud_enable_q |=>
    div_q == 16'h0001 && cal)
    else $error("Calibration did not start at one.");
  AST_CAL_DONE: assert property (s_last_rise |=>
    !autobaud_enable_q && rif_q && idle_q && st_q == ST_IDLE)
    else $error("Fifth rise did not finish calibration.");
  AST_IDLE_LOW: assert property (cal |-> !receiver_idle_flag && rx_hold_idle)
    else $error("Idle flag high while counting.");
  AST_OVF: assert property (cal && pre_hit && div_q == 16'hffff && !rise_ev |=>
    ovf_q && rif_q && div_q == 16'h0000 && cal)
    else $error("Overflow not flagged.");
  AST_WAKE: assert property ((st_q == ST_IDLE) && wake_on && fall_ev |=>
    rif_q && st_q == ST_WLOW ##0 rx_hold_idle)
    else $error("Wake event lost.");
  AST_WUE_CLR: assert property ((st_q == ST_WLOW) && rise_ev |=> !wue_q)
    else $error("Wake enable not cleared at break end.");
  AST_RD_CLR: assert property (rd && paddr == `UBW_OFS_RXDATA && !rif_set |=>
    !receive_int_flag)
    else $error("Data read did not clear flag.");
  AST_PERIOD: assert property (baud_tick |=> !baud_tick [*3])
    else $error("Baud ticks too close.");
  AST_APB: assert property (psel && !penable |=> pready)
    else $error("Bus answer late.");

  // An unmapped address is flagged together with the answer and never alone.
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("Error flag without a bus answer.");

  // Wake steps: the armed fall on the line, then the rise that ends the break.
  sequence s_wake_fall;
    st_q == ST_IDLE && wake_on && fall_ev;
  endsequence

  sequence s_break_end;
    st_q == ST_WLOW && rise_ev;
  endsequence

  // An armed fall always moves the sequencer into the break wait.
  AST_WAKE_LOW: assert property (s_wake_fall |=>
    st_q == ST_WLOW && !receiver_idle_flag)
    else $error("Armed fall did not start the break wait.");

  // With calibration armed too, the start bit is awaited once the break ends.
  AST_WAKE_THEN_CAL: assert property (s_break_end ##1 autobaud_enable_q |=>
    st_q == ST_FALL)
    else $error("Calibration not armed after the break.");

  // A fall in synchronous mode never arms the break wait.
  AST_SYNC_NO_WAKE: assert property (st_q == ST_IDLE && sync_q && fall_ev
    && !autobaud_enable_q |=> st_q == ST_IDLE)
    else $error("Wake taken in synchronous mode.");

  // Calibration and an armed wake both keep the receive machine parked.
  AST_HOLD_ABD: assert property (autobaud_enable_q |-> rx_hold_idle)
    else $error("Receiver not held during calibration.");
  AST_HOLD_WUE: assert property (wake_on |-> rx_hold_idle)
    else $error("Receiver not held while wake is armed.");

  // After the fifth rise the receiver stays parked only if wake is still armed.
  AST_RELEASE: assert property (s_last_rise |=> rx_hold_idle == wake_on)
    else $error("Receiver not released after calibration.");

  // A stored character raises the receive flag on the next edge.
  AST_CHAR_FLAG: assert property (rx_char_valid |=> receive_int_flag)
    else $error("Stored character did not raise the flag.");

  // Between prescale ticks the calibration count holds still.
  AST_CAL_HOLD: assert property (cal && !pre_hit |=> $stable(div_q))
    else $error("Calibration count moved off a prescale tick.");

  // Each prescale tick adds one to the full sixteen-bit count.
  AST_CAL_STEP: assert property (cal && pre_hit && !rise_ev && autobaud_enable_q && !wr |=>
    div_q == $past(div_q) + 16'h0001)
    else $error("Calibration count did not step by one.");

  // Divisor writes are refused while the sequencer waits on the line.
  AST_DIV_REFUSED: assert property (div_wr && st_q inside {ST_FALL, ST_WLOW} |=>
    $stable(div_q))
    else $error("Divisor changed by a refused write.");

  // With the sequencer idle, a full match of the pair ends the period in 16-bit mode.
  AST_TICK16: assert property (pre_hit && s16_q && st_q == ST_IDLE && !div_wr &&
    cnt_q == div_q |=> baud_tick && cnt_q == 16'h0000)
    else $error("Sixteen-bit divider missed its tick.");

  // In 8-bit mode only the low bytes are compared, so the high byte is ignored.
  AST_TICK8: assert property (pre_hit && !s16_q && st_q == ST_IDLE && !div_wr &&
    cnt_q[7:0] == div_q[7:0] |=> baud_tick && cnt_q == 16'h0000)
    else $error("Eight-bit divider missed its tick.");

endmodule

//--- tb/ubw_remote_tx.sv
// Purpose: Remote asynchronous transmitter that drives the receive line.
// Assumes: Bit time is given in pclk cycles; frames are 8N1, LSB first.
// Notes:   The line idles high and changes only just after a rising edge.
`timescale 1ns/1ps
module ubw_remote_tx (
  input  wire logic pclk,
  output logic      serial_rx_line
);
  // ----------------------------------------
  // Line drivers
  // ----------------------------------------
  // The line rests at the idle level until a frame begins.
  initial serial_rx_line = 1'h1;

  // Sends start bit, eight data bits and a stop bit, then leaves the line idle.
  task send_char(input logic [7:0] c, input int bt);
    logic [9:0] f;
    f = {1'h1, c, 1'h0};
    for (int i = 0; i < 10; i++) begin
      serial_rx_line <= f[i];
      repeat (bt) @(posedge pclk);
    end
  endtask

  // Holds the line low for a long all-zero wake character, then releases it.
  task send_break(input int nbits, input int bt);
    serial_rx_line <= 1'h0;
    repeat (nbits * bt) @(posedge pclk);
    serial_rx_line <= 1'h1;
    repeat (bt) @(posedge pclk);
  endtask
endmodule

//--- tb/uart_baud_autobaud_wake_tb.sv
// Purpose: Self-checking bench for the baud generator.
// Assumes: APB answers after one access cycle; pclk runs at 20 MHz.
// Notes:   Calibration bit times are multiples of the calibration prescale.
`timescale 1ns/1ps
`include "ubw_params.svh"
module uart_baud_autobaud_wake_tb;
  logic        pclk, presetn, psel, penable, pwrite, rx_char_valid;
  logic [7:0]  paddr, hi;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, baud_tick, rif, idle, hold, line;
  int          errors, n_compared, cyc, gap;
  int          pre_tab [4] = '{64, 16, 16, 4};

  ubw_baud_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_line(line), .rx_char_valid(rx_char_valid),
    .baud_tick(baud_tick), .receive_int_flag(rif), .receiver_idle_flag(idle),
    .rx_hold_idle(hold));
  ubw_remote_tx tx (.pclk(pclk), .serial_rx_line(line));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  // The clock toggles every half period of 25 ns.
  always #25 pclk = ~pclk;

  // Cuts a hung run short well above the expected length.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hv,
               input logic [31:0] g);
    n_compared++;
    if ((g >= lo && g <= hv) !== 1'h1) begin
      errors++;
      $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hv, g);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Counts the cycles between two successive divider ticks.
  task tick_gap(output int n);
    n = 0;
    do @(posedge pclk); while (baud_tick !== 1'h1);
    do begin
      @(posedge pclk);
      n++;
    end while (baud_tick !== 1'h1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // Resets the block, then walks through rates, calibration and wake.
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_char_valid = 1'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, `UBW_OFS_CTRL, 32'h0); chk("ctrl_rst", 32'h0, rd);
    apb(1'h0, `UBW_OFS_DIV_LO, 32'h0); chk("div_lo_rst", 32'h0, rd);
    apb(1'h0, `UBW_OFS_STATUS, 32'h0); chk("status_rst", 32'h2, rd);
    chk("hold_rst", 32'h0, {31'h0, hold});
    apb(1'h0, 8'h14, 32'h0); chk("unmapped_err", 32'h1, {31'h0, err});
    // Period is (low byte + 1) in 8-bit mode, (pair + 1) in 16-bit mode.
    for (int m = 0; m < 4; m++) begin
      apb(1'h1, `UBW_OFS_CTRL, {30'h0, m[0], m[1]});
      apb(1'h1, `UBW_OFS_DIV_HI, 32'h1);
      apb(1'h1, `UBW_OFS_DIV_LO, 32'h2);
      tick_gap(gap);
      chk("tick_gap", 32'(pre_tab[m] * (m[1] ? 259 : 3)), 32'(gap));
    end
    @(posedge pclk) rx_char_valid <= 1'h1;
    @(posedge pclk) rx_char_valid <= 1'h0;
    @(negedge pclk); chk("rif_char", 32'h1, {31'h0, rif});
    apb(1'h1, `UBW_OFS_STATUS, 32'h0);
    @(negedge pclk); chk("rif_ro", 32'h1, {31'h0, rif});
    apb(1'h0, `UBW_OFS_RXDATA, 32'h0);
    @(negedge pclk); chk("rif_clr", 32'h0, {31'h0, rif});
    // Calibration in an 8-bit mode; the count must run past one byte.
    apb(1'h1, `UBW_OFS_CTRL, 32'ha);
    fork
      tx.send_char(8'h55, 4352);
      begin
        repeat (13000) @(posedge pclk);
        chk("hold_cal", 32'h1, {31'h0, hold});
        chk("idle_cal", 32'h0, {31'h0, idle});
        apb(1'h1, `UBW_OFS_DIV_LO, 32'h77);
      end
    join
    @(negedge pclk);
    chk("rif_cal", 32'h1, {31'h0, rif});
    chk("idle_end", 32'h1, {31'h0, idle});
    apb(1'h0, `UBW_OFS_CTRL, 32'h0); chk("ctrl_cal", 32'h2, rd);
    apb(1'h0, `UBW_OFS_DIV_HI, 32'h0);
    hi = rd[7:0];
    apb(1'h0, `UBW_OFS_DIV_LO, 32'h0);
    chk_rng("divisor", 32'd272, 32'd274, {16'h0, hi, rd[7:0]});
    apb(1'h0, `UBW_OFS_RXDATA, 32'h0);
    @(negedge pclk); chk("rif_cal_clr", 32'h0, {31'h0, rif});
    // With the flag read away and the receiver idle, the overflow bit is cleared.
    apb(1'h1, `UBW_OFS_CTRL, 32'h2);
    apb(1'h0, `UBW_OFS_CTRL, 32'h0); chk("ovf_clr", 32'h2, rd);
    // Wake on break combined with calibration on the following character.
    chk("idle_pre", 32'h1, {31'h0, idle});
    apb(1'h1, `UBW_OFS_CTRL, 32'h1b);
    fork
      tx.send_break(13, 64);
      begin
        repeat (40) @(posedge pclk);
        chk("rif_wake", 32'h1, {31'h0, rif});
        chk("hold_wake", 32'h1, {31'h0, hold});
      end
    join
    apb(1'h0, `UBW_OFS_CTRL, 32'h0); chk("ctrl_wake", 32'hb, rd);
    apb(1'h0, `UBW_OFS_RXDATA, 32'h0);
    @(negedge pclk); chk("rif_wake_clr", 32'h0, {31'h0, rif});
    @(posedge pclk);
    tx.send_char(8'h55, 128);
    @(negedge pclk); chk("rif_cal2", 32'h1, {31'h0, rif});
    apb(1'h0, `UBW_OFS_DIV_HI, 32'h0);
    hi = rd[7:0];
    apb(1'h0, `UBW_OFS_DIV_LO, 32'h0);
    chk_rng("divisor2", 32'd32, 32'd34, {16'h0, hi, rd[7:0]});
    apb(1'h0, `UBW_OFS_RXDATA, 32'h0);
    // A falling line must not wake the block in synchronous mode.
    apb(1'h1, `UBW_OFS_CTRL, 32'h16);
    apb(1'h1, `UBW_OFS_DIV_LO, 32'h2);
    tx.send_break(13, 64);
    @(negedge pclk); chk("rif_sync", 32'h0, {31'h0, rif});
    // Synchronous mode ignores the high rate bit, so the slow prescale applies.
    tick_gap(gap);
    chk("tick_sync", 32'(pre_tab[0] * 3), 32'(gap));
    apb(1'h1, `UBW_OFS_CTRL, 32'h0);
    tally_and_finish;
  end
endmodule
